// [rtl/acc_ctrl.sv]
// Local design decisions: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module acc_ctrl
  import acc_pkg::*;
#(
  parameter int unsigned VREF_CYC = acc_pkg::VREF_STARTUP_CYC,  // reference start-up cycles
  parameter int unsigned AC_CYC   = acc_pkg::AC_STARTUP_CYC     // comparator start-up cycles
) (
  input  wire logic                      clock_i,          // peripheral clock, 250 MHz
  input  wire logic                      rstn_i,           // synchronous reset, active low
  // AHB-Lite slave
  input  wire logic                      hsel_i,           // slave select
  input  wire logic [acc_pkg::ADDR_W-1:0] haddr_i,         // byte address
  input  wire logic [1:0]                htrans_i,         // transfer type
  input  wire logic                      hwrite_i,         // write when high
  input  wire logic [2:0]                hsize_i,          // word transfers only
  input  wire logic                      hready_i,         // bus ready
  input  wire logic [acc_pkg::DATA_W-1:0] hwdata_i,        // write data
  output logic      [acc_pkg::DATA_W-1:0] hrdata_o,        // read data
  output logic                           hreadyout_o,      // slave ready
  output logic                           hresp_o,          // always OKAY
  // analog front end and system
  input  wire logic                      cmp_raw_i,        // analog comparator decision
  input  wire logic [1:0]                sleep_mode_i,     // sleep state
  input  wire logic                      clk_req_other_i,  // clock kept by another module
  output logic                           comp_on_o,        // power to comparator
  output logic                           pos_source_sel_o, // positive mux select
  output logic      [1:0]                neg_source_sel_o, // negative mux select
  output logic      [1:0]                hyst_level_o,     // hysteresis level
  output logic                           vref_req_o,       // request internal reference
  output logic                           result_valid_o,   // start-up time elapsed
  output logic                           event_o,          // asynchronous event source
  output logic                           pad_o,            // comparator pad output
  output logic                           pad_oe_n_o,       // pad output enable, low drives
  output logic                           irq_o             // interrupt request
);
  import acc_pkg::*;

  localparam logic [STARTUP_CNT_W-1:0] AC_LOAD   = STARTUP_CNT_W'(AC_CYC - 1);
  localparam logic [STARTUP_CNT_W-1:0] VREF_LOAD = STARTUP_CNT_W'(VREF_CYC - 1);

  logic [REG_W-1:0]         ctrl_r;
  logic [REG_W-1:0]         insel_r;
  logic                     irq_en_r;
  logic                     flag_r;
  logic                     flag_nxt;
  logic                     irq_r;
  logic                     run_r;
  logic                     upd_r;
  logic                     run_nxt;
  logic                     upd_nxt;
  logic [DATA_W-1:0]        hrdata_r;
  logic                     wr_pend_r;
  logic [ADDR_W-1:0]        wr_addr_r;
  logic [STARTUP_CNT_W-1:0] cnt_r;
  acc_state_t               st_r;
  logic                     pad_oe_n_r;
  logic                     vref_req_r;

  logic       enable;
  logic       standby_run;
  logic       pad_drive_en;
  logic [1:0] edge_select;
  logic       invert;
  logic       result;
  logic       state_bit;
  logic       rise;
  logic       fall;
  logic       edge_hit;
  logic       flag_set;
  logic       flag_clr;
  logic       addr_ok;
  logic       wr_ctrl;
  logic       wr_insel;
  logic       wr_ie;
  logic       wr_stat;
  logic [REG_W-1:0] rd_val;

  assign enable       = ctrl_r[CA_ENABLE_BIT];
  assign standby_run  = ctrl_r[CA_STBY_BIT];
  assign pad_drive_en = ctrl_r[CA_PAD_BIT];
  assign edge_select  = ctrl_r[CA_EDGE_LSB +: 2];
  assign invert       = insel_r[IS_INVERT_BIT];

  // bus: zero wait states, address phase captured, write applied in data phase
  assign addr_ok = hsel_i & htrans_i[1] & hready_i;

  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end
    else
    begin
      wr_pend_r <= addr_ok & hwrite_i;
      wr_addr_r <= haddr_i;
    end
  end

  assign wr_ctrl  = wr_pend_r & (wr_addr_r == ADDR_CONTROL_A);
  assign wr_insel = wr_pend_r & (wr_addr_r == ADDR_INPUT_SELECT);
  assign wr_ie    = wr_pend_r & (wr_addr_r == ADDR_IRQ_ENABLE);
  assign wr_stat  = wr_pend_r & (wr_addr_r == ADDR_STATUS);

  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      ctrl_r  <= CONTROL_A_RST;
      insel_r <= INPUT_SELECT_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= {hwdata_i[7:4], 1'b0, hwdata_i[2:0]};
      if (wr_insel)
        insel_r <= {hwdata_i[7], 3'b000, hwdata_i[3], 1'b0, hwdata_i[1:0]};
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
      irq_en_r <= IRQ_ENABLE_RST[IE_CMP_BIT];
    else if (wr_ie)
      irq_en_r <= hwdata_i[IE_CMP_BIT];
  end

  // read data is fetched at the address phase edge and held for the data phase
  always_comb
  begin
    rd_val = '0;
    case (haddr_i)
      ADDR_CONTROL_A:    rd_val = ctrl_r;
      ADDR_INPUT_SELECT: rd_val = insel_r;
      ADDR_IRQ_ENABLE:   rd_val = {7'h00, irq_en_r};
      ADDR_STATUS:       rd_val = {3'h0, state_bit, 3'h0, flag_r};
      default:           rd_val = '0;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
      hrdata_r <= '0;
    else if (addr_ok & ~hwrite_i)
      hrdata_r <= {24'h000000, rd_val};
  end

  assign hrdata_o    = hrdata_r;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  // sleep gating: idle changes nothing; standby needs standby_run
  always_comb
  begin
    run_nxt = enable;
    upd_nxt = enable;
    case (sleep_mode_i)
      SLP_STANDBY:
      begin
        run_nxt = enable & standby_run;
        upd_nxt = enable & standby_run & clk_req_other_i;
      end
      SLP_PDOWN:
      begin
        run_nxt = 1'b0;
        upd_nxt = 1'b0;
      end
      default:
      begin
        run_nxt = enable;
        upd_nxt = enable;
      end
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      run_r <= 1'b0;
      upd_r <= 1'b0;
    end
    else
    begin
      run_r <= run_nxt;
      upd_r <= upd_nxt;
    end
  end

  // pad enable and reference request leave from flops, in step with run_r
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      pad_oe_n_r <= 1'b1;
      vref_req_r <= 1'b0;
    end
    else
    begin
      pad_oe_n_r <= ~(run_nxt & pad_drive_en);
      vref_req_r <= run_nxt & (insel_r[IS_NEG_LSB +: 2] == NEG_VREF);
    end
  end

  // start-up wait; with the reference selected the longer reference time rules
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      st_r  <= ACC_ST_OFF;
      cnt_r <= '0;
    end
    else
    begin
      case (st_r)
        ACC_ST_OFF:
          if (run_r)
          begin
            st_r  <= ACC_ST_WARM;
            cnt_r <= (insel_r[IS_NEG_LSB +: 2] == NEG_VREF) ? VREF_LOAD : AC_LOAD;
          end
        ACC_ST_WARM:
          if (!run_r)
            st_r <= ACC_ST_OFF;
          else if (cnt_r == '0)
            st_r <= ACC_ST_READY;
          else
            cnt_r <= cnt_r - 1'b1;
        ACC_ST_READY:
          if (!run_r)
            st_r <= ACC_ST_OFF;
        default:
          st_r <= ACC_ST_OFF;
      endcase
    end
  end

  // result is inverted before every consumer
  assign result = cmp_raw_i ^ invert;

  // gated like the event: state reads zero while off and no stale edge follows enable
  acc_sync_edge u_sync (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .async_i (result & run_r),
    .state_o (state_bit),
    .rise_o  (rise),
    .fall_o  (fall)
  );

  always_comb
  begin
    case (edge_select)
      EDGE_BOTH: edge_hit = rise | fall;
      EDGE_FALL: edge_hit = fall;
      EDGE_RISE: edge_hit = rise;
      default:   edge_hit = 1'b0;
    endcase
  end

  // a set arriving with a clear wins, so no edge is lost
  assign flag_set = upd_r & (st_r == ACC_ST_READY) & edge_hit;
  assign flag_clr = wr_stat & hwdata_i[ST_FLAG_BIT];
  assign flag_nxt = flag_set | (flag_r & ~flag_clr);

  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      flag_r <= 1'b0;
      irq_r  <= 1'b0;
    end
    else
    begin
      flag_r <= flag_nxt;
      irq_r  <= flag_nxt & (wr_ie ? hwdata_i[IE_CMP_BIT] : irq_en_r);
    end
  end

  assign irq_o = irq_r;

  // event and pad are not synchronised: only the gate comes from a flop
  assign event_o    = result & run_r;
  assign pad_o      = result & ~pad_oe_n_r;
  assign pad_oe_n_o = pad_oe_n_r;

  assign comp_on_o        = run_r;
  assign pos_source_sel_o = insel_r[IS_POS_BIT];
  assign neg_source_sel_o = insel_r[IS_NEG_LSB +: 2];
  assign hyst_level_o     = ctrl_r[CA_HYST_LSB +: 2];
  assign vref_req_o       = vref_req_r;
  assign result_valid_o   = (st_r == ACC_ST_READY);

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  flag_set_a: assert property (flag_set |=> flag_r)
    else $error("flag not set after matching edge");
  flag_clear_a: assert property (flag_r && flag_clr && !flag_set |=> !flag_r)
    else $error("write one did not clear flag");
  flag_hold_a: assert property (flag_r && !flag_clr |=> flag_r)
    else $error("flag dropped without a clear");
  irq_level_a: assert property (irq_o == (flag_r && irq_en_r))
    else $error("irq does not follow flag and enable");
  edge_mode_a: assert property (edge_select == EDGE_RISE && fall |-> !flag_set)
    else $error("falling edge set flag in rising mode");
  disabled_a: assert property (!enable |=> !event_o && !pad_o && !flag_set)
    else $error("disabled block drove event, pad or flag");
  power_down_a: assert property (sleep_mode_i == SLP_PDOWN |=> !comp_on_o && pad_oe_n_o)
    else $error("power-down left comparator or pad on");
  standby_a: assert property (sleep_mode_i == SLP_STANDBY && !standby_run |=> !run_r)
    else $error("standby without run left block on");
  startup_a: assert property ($rose(run_r) && neg_source_sel_o == NEG_PIN
    |-> !result_valid_o [*8])
    else $error("result valid before start-up time");
  event_inv_a: assert property (run_r |-> event_o == (cmp_raw_i ^ invert))
    else $error("event does not follow inverted result");

  cov_rise_c:  cover property (edge_select == EDGE_RISE && flag_set);
  cov_clash_c: cover property (flag_set && flag_clr);
  cov_vref_c:  cover property (vref_req_o && result_valid_o);
  cov_stby_c:  cover property (sleep_mode_i == SLP_STANDBY && run_r && !upd_r);
  cov_inv_c:   cover property (invert && flag_set);
endmodule

// [rtl/acc_pkg.sv]
package acc_pkg;

  // bus geometry
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned REG_W      = 8;

  // printed register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_CONTROL_A    = 8'h00;
  localparam logic [ADDR_W-1:0] IDX_INPUT_SELECT = 8'h02;
  localparam logic [ADDR_W-1:0] IDX_IRQ_ENABLE   = 8'h06;
  localparam logic [ADDR_W-1:0] IDX_STATUS       = 8'h07;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL_A    = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_INPUT_SELECT = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE   = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_STATUS       = 8'h1C;

  // control_a_reg fields
  localparam int unsigned CA_ENABLE_BIT   = 0;
  localparam int unsigned CA_HYST_LSB     = 1;
  localparam int unsigned CA_EDGE_LSB     = 4;
  localparam int unsigned CA_PAD_BIT      = 6;
  localparam int unsigned CA_STBY_BIT     = 7;
  // input_select_reg fields
  localparam int unsigned IS_NEG_LSB      = 0;
  localparam int unsigned IS_POS_BIT      = 3;
  localparam int unsigned IS_INVERT_BIT   = 7;
  // irq_enable_reg and status fields
  localparam int unsigned IE_CMP_BIT      = 0;
  localparam int unsigned ST_FLAG_BIT     = 0;
  localparam int unsigned ST_STATE_BIT    = 4;

  localparam logic [REG_W-1:0] CONTROL_A_RST    = 8'h00;
  localparam logic [REG_W-1:0] INPUT_SELECT_RST = 8'h00;
  localparam logic [REG_W-1:0] IRQ_ENABLE_RST   = 8'h00;

  // edge_select encodings
  localparam logic [1:0] EDGE_BOTH = 2'h0;
  localparam logic [1:0] EDGE_RSVD = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_RISE = 2'h3;
  // neg_source_sel encodings
  localparam logic [1:0] NEG_PIN   = 2'h0;
  localparam logic [1:0] NEG_VREF  = 2'h2;

  // sleep state from the power manager
  localparam logic [1:0] SLP_ACTIVE  = 2'h0;
  localparam logic [1:0] SLP_IDLE    = 2'h1;
  localparam logic [1:0] SLP_STANDBY = 2'h2;
  localparam logic [1:0] SLP_PDOWN   = 2'h3;

  // start-up times and derived cycle counts (round up)
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned AC_STARTUP_NS    = 2500;
  localparam int unsigned VREF_STARTUP_NS  = 60000;
  localparam int unsigned AC_STARTUP_CYC   = (AC_STARTUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned VREF_STARTUP_CYC = (VREF_STARTUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned STARTUP_CNT_W    = 16;

  typedef enum logic [2:0] {
    ACC_ST_OFF   = 3'b001,
    ACC_ST_WARM  = 3'b010,
    ACC_ST_READY = 3'b100
  } acc_state_t;

endpackage

// [rtl/acc_sync_edge.sv]
`timescale 1ns/1ps
module acc_sync_edge (
  input  wire logic clock_i,   // peripheral clock
  input  wire logic rstn_i,    // synchronous reset, active low
  input  wire logic async_i,   // comparator result, asynchronous
  output logic      state_o,   // result, three cycles late
  output logic      rise_o,    // one-cycle pulse on rising edge
  output logic      fall_o     // one-cycle pulse on falling edge
);
  logic meta_r;
  logic sync_r;
  logic state_r;

  // two-flop synchroniser plus a held sample: three cycles of lag
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      meta_r  <= 1'b0;
      sync_r  <= 1'b0;
      state_r <= 1'b0;
    end
    else
    begin
      meta_r  <= async_i;
      sync_r  <= meta_r;
      state_r <= sync_r;
    end
  end

  // edge is the synchronised value against its previous sample
  assign rise_o  = sync_r & ~state_r;
  assign fall_o  = ~sync_r & state_r;
  assign state_o = state_r;

  state_follows_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    rise_o |=> state_o)
    else $error("state bit did not follow a rising edge");
endmodule

// [tb/acc_analog_model.sv]
`timescale 1ns/1ps
module acc_analog_model
  import acc_pkg::*;
#(
  parameter logic [15:0] VREF_MV = 16'h044C  // internal reference level, mV
) (
  input  wire logic        clock_i,          // peripheral clock
  input  wire logic        comp_on_i,        // comparator powered
  input  wire logic [1:0]  neg_source_sel_i, // negative source select
  input  wire logic [15:0] pos_mv_i,         // positive pin level, mV
  input  wire logic [15:0] neg_mv_i,         // negative pin level, mV
  output logic             cmp_raw_o         // comparator decision
);
  logic [15:0] neg_lvl;
  logic        live;
  logic        held_r = 1'b0;

  assign neg_lvl = (neg_source_sel_i == NEG_VREF) ? VREF_MV : neg_mv_i;
  // levels only: no digital input buffer is modelled on these pins
  assign live    = (pos_mv_i > neg_lvl);  // equality reads low
  // unpowered comparator has no valid decision: flip the last one so missing gating shows
  always_ff @(posedge clock_i)
    if (comp_on_i)
      held_r <= live;
  assign cmp_raw_o = comp_on_i ? live : ~held_r;
endmodule

// [tb/tb_analog_comparator_ctrl.sv]
`timescale 1ns/1ps
module tb_analog_comparator_ctrl;
  import acc_pkg::*;
  localparam int unsigned AC_N   = 10;
  localparam int unsigned VREF_N = 20;
  localparam int          LIMIT  = 20000;
  logic                clock_i = 1'b0;
  logic                rstn_i  = 1'b0;
  logic                hsel    = 1'b0;
  logic [ADDR_W-1:0]   haddr   = '0;
  logic [1:0]          htrans  = 2'h0;
  logic                hwrite  = 1'b0;
  logic [2:0]          hsize   = 3'h2;
  logic [DATA_W-1:0]   hwdata  = '0;
  logic [1:0]          sleep   = SLP_ACTIVE;
  logic                clk_req = 1'b0;
  logic [15:0]         pos_mv  = 16'h0064;
  logic [15:0]         neg_mv  = 16'h01F4;
  logic [DATA_W-1:0]   rd;
  wire logic [DATA_W-1:0] hrdata;
  wire logic           hready, hresp, cmp_raw, comp_on, pos_sel, vref_req, valid;
  wire logic           ev, pad, pad_oe_n, irq;
  wire logic [1:0]     neg_sel, hyst;
  int                  n_fail = 0;
  int                  comparisons = 0;
  int                  cycles = 0;

  always #2 clock_i = ~clock_i;

  acc_ctrl #(.VREF_CYC(VREF_N), .AC_CYC(AC_N)) dut_u (
    .clock_i(clock_i), .rstn_i(rstn_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hready_i(hready), .hwdata_i(hwdata), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .cmp_raw_i(cmp_raw), .sleep_mode_i(sleep),
    .clk_req_other_i(clk_req), .comp_on_o(comp_on), .pos_source_sel_o(pos_sel),
    .neg_source_sel_o(neg_sel), .hyst_level_o(hyst), .vref_req_o(vref_req),
    .result_valid_o(valid), .event_o(ev), .pad_o(pad), .pad_oe_n_o(pad_oe_n), .irq_o(irq));

  acc_analog_model model_u (
    .clock_i(clock_i), .comp_on_i(comp_on), .neg_source_sel_i(neg_sel),
    .pos_mv_i(pos_mv), .neg_mv_i(neg_mv), .cmp_raw_o(cmp_raw));

  task automatic summarize();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_ready();
    @(posedge clock_i);
    while (hready !== 1'b1)
      @(posedge clock_i);
  endtask

  // address phase held until ready, then data phase held until ready
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock_i);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
    hsel <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    bus(1'b0, a, '0);
    check(rd, exp);
  endtask

  // sync chain plus flag and irq stages take three edges; three spare
  task automatic settle();
    repeat (6) @(posedge clock_i);
  endtask

  task automatic set_mv(input logic [15:0] mv);
    @(posedge clock_i);
    pos_mv <= mv;
    settle();
  endtask

  task automatic wait_valid(output int n);
    n = 0;
    while (valid !== 1'b1)
    begin
      @(posedge clock_i);
      n++;
    end
  endtask

  task automatic t_regs();
    rdchk(ADDR_CONTROL_A, 32'h0);
    rdchk(ADDR_INPUT_SELECT, 32'h0);
    rdchk(ADDR_IRQ_ENABLE, 32'h0);
    rdchk(ADDR_STATUS, 32'h0);
    check(32'({hready, hresp}), 32'h2);
    wr(ADDR_CONTROL_A, 32'h000000F6);
    rdchk(ADDR_CONTROL_A, 32'h000000F6);
    wr(ADDR_INPUT_SELECT, 32'hFFFFFFFF);
    rdchk(ADDR_INPUT_SELECT, 32'h0000008B);
    check(32'(hyst), 32'h3);
    check(32'(pos_sel), 32'h1);
    check(32'(neg_sel), 32'h3);
    check(32'({ev, pad}), 32'h0);
    wr(ADDR_IRQ_ENABLE, 32'hFFFFFFFF);
    rdchk(ADDR_IRQ_ENABLE, 32'h1);
    wr(8'h04, 32'hFFFFFFFF);
    rdchk(8'h04, 32'h0);
    wr(ADDR_CONTROL_A, 32'h0);
    wr(ADDR_INPUT_SELECT, 32'h0);
    wr(ADDR_IRQ_ENABLE, 32'h0);
  endtask

  task automatic t_start();
    int n;
    wr(ADDR_CONTROL_A, 32'h41);
    wait_valid(n);
    check(32'(n >= AC_N), 32'h1);
    set_mv(16'd900);
    check(32'({ev, pad, pad_oe_n}), 32'h6);
    set_mv(16'd500);
    check(32'(ev), 32'h0);
    wr(ADDR_CONTROL_A, 32'h0);
    wr(ADDR_INPUT_SELECT, 32'h02);
    wr(ADDR_CONTROL_A, 32'h41);
    wait_valid(n);
    check(32'(n >= VREF_N), 32'h1);
    check(32'(vref_req), 32'h1);
    set_mv(16'd1500);
    check(32'(ev), 32'h1);
    set_mv(16'd900);
    check(32'(ev), 32'h0);
    wr(ADDR_INPUT_SELECT, 32'h0);
    settle();
    check(32'(ev), 32'h1);
  endtask

  task automatic t_edges();
    logic [1:0] m;
    logic       rf;
    logic       ff;
    for (int i = 0; i < 4; i++)
    begin
      m  = 2'(i);
      rf = (m == EDGE_BOTH) || (m == EDGE_RISE);
      ff = (m == EDGE_BOTH) || (m == EDGE_FALL);
      set_mv(16'd100);
      wr(ADDR_CONTROL_A, {25'h0, 1'b1, m, 4'h1});
      wr(ADDR_STATUS, 32'h1);
      set_mv(16'd900);
      rdchk(ADDR_STATUS, {27'h0, 1'b1, 3'h0, rf});
      wr(ADDR_STATUS, 32'h1);
      set_mv(16'd100);
      rdchk(ADDR_STATUS, {31'h0, ff});
    end
    wr(ADDR_INPUT_SELECT, 32'h80);
    settle();
    check(32'({ev, pad}), 32'h3);
    rdchk(ADDR_STATUS, 32'h11);
    wr(ADDR_INPUT_SELECT, 32'h0);
  endtask

  task automatic t_irq();
    wr(ADDR_CONTROL_A, 32'h01);
    wr(ADDR_STATUS, 32'h1);
    set_mv(16'd900);
    check(32'(irq), 32'h0);
    wr(ADDR_IRQ_ENABLE, 32'h1);
    settle();
    check(32'(irq), 32'h1);
    wr(ADDR_STATUS, 32'h0);
    rdchk(ADDR_STATUS, 32'h11);
    check(32'(irq), 32'h1);
    wr(ADDR_STATUS, 32'h1);
    settle();
    check(32'(irq), 32'h0);
    rdchk(ADDR_STATUS, 32'h10);
  endtask

  task automatic t_sleep();
    @(posedge clock_i);
    sleep <= SLP_IDLE;
    set_mv(16'd100);
    check(32'(irq), 32'h1);
    wr(ADDR_STATUS, 32'h1);
    wr(ADDR_CONTROL_A, 32'hC1);
    @(posedge clock_i);
    sleep <= SLP_STANDBY;
    set_mv(16'd900);
    check(32'({ev, pad, irq}), 32'h6);
    bus(1'b0, ADDR_STATUS, '0);
    check(rd & 32'h1, 32'h0);
    @(posedge clock_i);
    sleep <= SLP_PDOWN;
    settle();
    check(32'({ev, pad}), 32'h0);
    check(32'({comp_on, pad_oe_n}), 32'h1);
    @(posedge clock_i);
    sleep <= SLP_STANDBY;
    wr(ADDR_CONTROL_A, 32'h41);
    settle();
    check(32'({ev, pad}), 32'h0);
    @(posedge clock_i);
    sleep <= SLP_ACTIVE;
  endtask

  task automatic t_off();
    wr(ADDR_CONTROL_A, 32'h40);
    wr(ADDR_STATUS, 32'h1);
    set_mv(16'd100);
    set_mv(16'd900);
    check(32'({ev, pad}), 32'h0);
    bus(1'b0, ADDR_STATUS, '0);
    check(rd & 32'h1, 32'h0);
  endtask

  always @(posedge clock_i)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      n_fail++;
      summarize();
    end
  end

  initial
  begin
    repeat (5) @(posedge clock_i);
    rstn_i <= 1'b1;
    t_regs();
    t_start();
    t_edges();
    t_irq();
    t_sleep();
    t_off();
    summarize();
  end
endmodule
